// file: verilog/ds3_datalink_message_receiver.sv
// datalink message receiver: frames, header capture, buffer, apb registers
// assumes datalink bits come from framer logic on pclk, apb master on pclk
`timescale 1ns/100ps
`include "msg_rx_defs.svh"

// Function
// - Frames are taken only while the receiver-on bit is 1, which resets to 0.
// - With its enable set, completion raises an interrupt after payload storage.
// - The completion flag sets on a stored message and clears when software reads it.
// - The abort bit reads 1 while seven or more ones in a row are seen, else 0.
// - Bits 5:4 give the message kind, three short kinds and one long kind.
// - A status bit holds the command/response bit of the latest frame header.
// - A status bit reads 1 when the latest frame failed its check sequence.
// - The end-of-message bit sets once a whole frame has been received.
// - The end-of-message bit clears once a valid header of a new frame arrives.
// - The flag-present bit reads 1 while the flag byte is seen on the link.
module ds3_datalink_message_receiver import msg_rx_pkg::*; (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // datalink bits from the framer
    input wire logic datalink_overhead_bits,
    input wire logic datalink_bit_valid,
    // interrupt
    output logic irq
);
    rx_state_t st;
    rx_state_t next_st;
    dfr_evt_t evt;
    reg_sel_t sel;
    logic [31:0] rd_word;
    logic [6:0] buf_idx;
    logic [7:0] buf_rd;
    logic [6:0] exp_len;
    logic frame_bad;
    logic acc_rd;
    logic acc_wr;
    logic done_now;

    // =========================================================
    // register address decode, shared by reads and writes
    function automatic reg_sel_t decode(input logic [11:0] a);
        logic [9:0] w;
        w = a[11:2];
        if (a[1:0] != 2'h0) begin
            decode = SEL_NONE;
        end else if (w == `IDX_CTRL) begin
            decode = SEL_CTRL;
        end else if (w == `IDX_STAT) begin
            decode = SEL_STAT;
        end else if (w == `IDX_EVT_STAT) begin
            decode = SEL_ESTAT;
        end else if (w == `IDX_EVT_CLR) begin
            decode = SEL_ECLR;
        end else if (w == `IDX_EVT_EN) begin
            decode = SEL_EEN;
        end else if (w >= `IDX_BUF && w < `IDX_BUF_END) begin
            decode = SEL_BUF;
        end else begin
            decode = SEL_NONE;
        end
    endfunction : decode

    // =========================================================
    // bit level framing and payload storage
    hdlc_bit_deframer u_deframer (
        .pclk(pclk),
        .presetn(presetn),
        .bit_in(datalink_overhead_bits),
        .bit_valid(datalink_bit_valid),
        .evt(evt)
    );

    payload_store u_store (
        .pclk(pclk),
        .presetn(presetn),
        .wr(st.bw),
        .rd_idx(buf_idx),
        .rd_data(buf_rd)
    );

    // =========================================================
    // bus decode and handshake
    assign sel = decode(paddr);
    assign acc_rd = psel && penable && !pwrite;
    assign acc_wr = psel && penable && pwrite;
    assign buf_idx = 7'(paddr[11:2] - `IDX_BUF);
    // zero wait states: data was captured in the setup cycle
    assign pready = psel && penable;
    assign pslverr = psel && penable && (sel == SEL_NONE);
    assign prdata = st.prdata;

    // read word; clear register is write-only and reads zero
    always_comb begin
        rd_word = 32'h0000_0000;
        case (sel)
            SEL_CTRL: begin
                rd_word[`CTRL_ON:`CTRL_FLAG] = {st.on, st.irq_en, st.flag};
            end
            SEL_STAT: begin
                rd_word[6:0] = {evt.abort, st.kind, st.cr,
                                st.fcs_bad, st.finished, evt.flag_on};
            end
            SEL_ESTAT: begin
                rd_word[`EV_W-1:0] = st.evt_status;
            end
            SEL_EEN: begin
                rd_word[`EV_W-1:0] = st.evt_en;
            end
            SEL_BUF: begin
                rd_word[7:0] = buf_rd;
            end
            default: begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    // =========================================================
    // completion checks: length follows the kind, long kind is longer
    assign exp_len = (st.hdr_kind == `KIND_INTL) ? `LEN_LONG : `LEN_SHORT;
    assign frame_bad = !evt.crc_good || (st.wr_idx != exp_len);

    // =========================================================
    // next state: bus side first so hardware sets below win over clears
    always_comb begin
        next_st = st;
        next_st.bw.en = 1'b0;
        next_st.abort_q = evt.abort;
        done_now = 1'b0;
        if (psel && !penable) begin
            next_st.prdata = rd_word;
        end
        // only a flag that was actually returned is cleared
        if (acc_rd && sel == SEL_CTRL && st.prdata[`CTRL_FLAG]) begin
            next_st.flag = 1'b0;
        end
        if (acc_wr) begin
            case (sel)
                SEL_CTRL: begin
                    next_st.on = pwdata[`CTRL_ON];
                    next_st.irq_en = pwdata[`CTRL_IEN];
                end
                SEL_ECLR: begin
                    next_st.evt_status = st.evt_status & ~pwdata[`EV_W-1:0];
                end
                SEL_EEN: begin
                    next_st.evt_en = pwdata[`EV_W-1:0];
                end
                default: begin
                    next_st.evt_en = st.evt_en;
                end
            endcase
        end
        // message sequence; disabling drops any frame in progress
        if (!st.on) begin
            next_st.fsm = ST_HUNT;
        end else if (evt.abort) begin
            next_st.fsm = ST_HUNT;
        end else begin
            case (st.fsm)
                ST_HUNT: begin
                    if (evt.flag) begin
                        next_st.fsm = ST_HEAD;
                        next_st.hdr_cnt = 2'h0;
                    end
                end
                ST_HEAD: begin
                    if (evt.flag) begin
                        next_st.hdr_cnt = 2'h0;
                    end else if (evt.byte_ok) begin
                        if (st.hdr_cnt == `HDR_CR_BYTE) begin
                            next_st.hdr_cr = evt.data[`CR_BIT];
                        end
                        if (st.hdr_cnt == `HDR_LAST) begin
                            next_st.hdr_kind = evt.data[1:0];
                            next_st.fsm = ST_BODY;
                            next_st.finished = 1'b0;
                            next_st.nheld = 2'h0;
                            next_st.wr_idx = 7'h00;
                        end
                        next_st.hdr_cnt = st.hdr_cnt + 2'h1;
                    end
                end
                ST_BODY: begin
                    if (evt.flag) begin
                        done_now = 1'b1;
                        next_st.fsm = ST_HEAD;
                        next_st.hdr_cnt = 2'h0;
                    end else if (evt.byte_ok) begin
                        // two bytes held back: the last two are the check sequence
                        if (st.nheld == `HOLD_FULL) begin
                            if (st.wr_idx != `BUF_DEPTH) begin
                                next_st.bw.en = 1'b1;
                                next_st.bw.idx = st.wr_idx;
                                next_st.bw.data = st.hold1;
                                next_st.wr_idx = st.wr_idx + 7'h01;
                            end
                        end else begin
                            next_st.nheld = st.nheld + 2'h1;
                        end
                        next_st.hold1 = st.hold0;
                        next_st.hold0 = evt.data;
                    end
                end
                default: begin
                    next_st.fsm = ST_HUNT;
                end
            endcase
        end
        // completion: last write left one byte earlier, so buffer is settled
        if (done_now) begin
            next_st.kind = st.hdr_kind;
            next_st.cr = st.hdr_cr;
            next_st.fcs_bad = frame_bad;
            next_st.finished = 1'b1;
            next_st.flag = 1'b1;
            next_st.evt_status[`EV_DONE] = 1'b1;
            if (frame_bad) begin
                next_st.evt_status[`EV_FCS] = 1'b1;
            end
        end
        if (st.on && evt.abort && !st.abort_q) begin
            next_st.evt_status[`EV_ABORT] = 1'b1;
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // =========================================================
    // interrupt: completion flag plus the event register group
    assign irq = (st.flag && st.irq_en) || |(st.evt_status & st.evt_en);

    // =========================================================
    // assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_hdr_done;
        st.fsm == ST_HEAD ##1 st.fsm == ST_BODY;
    endsequence

    sequence s_ctrl_read;
        acc_rd && sel == SEL_CTRL && st.prdata[`CTRL_FLAG] && !done_now;
    endsequence

    a_off_hunts: assert property (!st.on |=> st.fsm == ST_HUNT)
        else $error("receiver left hunt while disabled");
    a_done_irq: assert property (done_now && st.irq_en && !acc_wr |=> irq)
        else $error("no interrupt after completion");
    a_read_clear: assert property (s_ctrl_read |=> !st.flag)
        else $error("completion flag not cleared by read");
    a_abort_hunt: assert property (evt.abort |=> st.fsm == ST_HUNT)
        else $error("abort did not drop the frame");
    a_kind_cr: assert property (done_now |=> st.kind == $past(st.hdr_kind)
        && st.cr == $past(st.hdr_cr))
        else $error("kind or command bit not latched");
    a_fcs_report: assert property (done_now && !evt.crc_good |=> st.fcs_bad)
        else $error("check sequence error not reported");
    a_eom_set: assert property (done_now |=> st.finished && st.flag)
        else $error("end of message not set");
    a_eom_clear: assert property (s_hdr_done |-> !st.finished)
        else $error("end of message not cleared after header");
    a_flag_seen: assert property (evt.flag |-> evt.flag_on)
        else $error("flag present low on flag");
    a_payload_first: assert property ($rose(st.finished) |-> !st.bw.en
        && !$past(st.bw.en))
        else $error("buffer write pending at completion");
    a_irq_level: assert property (st.flag && st.irq_en |-> irq)
        else $error("interrupt low with flag and enable set");
endmodule : ds3_datalink_message_receiver

// file: verilog/msg_rx_defs.svh
// constants of the datalink message receiver: offsets, fields, codes
// assumes nothing; included by the package and every design file
`ifndef MSG_RX_DEFS_SVH
`define MSG_RX_DEFS_SVH
// register word indices, byte address is four times the index
`define IDX_CTRL 10'h018
`define IDX_STAT 10'h019
`define IDX_EVT_STAT 10'h01A
`define IDX_EVT_CLR 10'h01B
`define IDX_EVT_EN 10'h01C
`define IDX_BUF 10'h040
`define IDX_BUF_END 10'h092
// control and status field positions
`define CTRL_ON 2
`define CTRL_IEN 1
`define CTRL_FLAG 0
`define EV_DONE 0
`define EV_ABORT 1
`define EV_FCS 2
`define EV_W 3
// frame layout and codes
`define BUF_WORDS 82
`define BUF_DEPTH 7'h52
`define LEN_SHORT 7'h4C
`define LEN_LONG 7'h52
`define KIND_INTL 2'h3
`define HDR_CR_BYTE 2'h0
`define HDR_LAST 2'h3
`define CR_BIT 1
`define HOLD_FULL 2'h2
`define FLAG_BYTE 8'h7E
`define ONES_STUFF 3'h5
`define ONES_ABORT 3'h7
`define CRC_INIT 16'hFFFF
`define CRC_POLY 16'h8408
`define CRC_GOOD 16'hF0B8
`endif

// file: verilog/msg_rx_pkg.sv
// types shared by the datalink message receiver modules
// assumes msg_rx_defs.svh is on the include path
package msg_rx_pkg;
`include "msg_rx_defs.svh"
    // =========================================================
    // enumerations
    typedef enum logic [1:0] {ST_HUNT, ST_HEAD, ST_BODY} rx_phase_t;
    typedef enum logic [2:0] {
        SEL_CTRL, SEL_STAT, SEL_ESTAT, SEL_ECLR, SEL_EEN, SEL_BUF, SEL_NONE
    } reg_sel_t;
    // =========================================================
    // carriers and state records
    typedef struct packed {
        logic flag;
        logic abort;
        logic byte_ok;
        logic [7:0] data;
        logic crc_good;
        logic flag_on;
    } dfr_evt_t;
    typedef struct packed {
        logic [7:0] shift;
        logic [2:0] ones;
        logic [2:0] nbits;
        logic [7:0] acc;
        logic [15:0] crc;
        dfr_evt_t evt;
    } dfr_state_t;
    typedef struct packed {
        logic en;
        logic [6:0] idx;
        logic [7:0] data;
    } buf_wr_t;
    typedef struct packed {
        logic [`BUF_WORDS-1:0][7:0] mem;
    } buf_state_t;
    typedef struct packed {
        rx_phase_t fsm;
        logic [1:0] hdr_cnt;
        logic hdr_cr;
        logic [1:0] hdr_kind;
        logic [7:0] hold0;
        logic [7:0] hold1;
        logic [1:0] nheld;
        logic [6:0] wr_idx;
        buf_wr_t bw;
        logic on;
        logic irq_en;
        logic flag;
        logic [1:0] kind;
        logic cr;
        logic fcs_bad;
        logic finished;
        logic abort_q;
        logic [`EV_W-1:0] evt_status;
        logic [`EV_W-1:0] evt_en;
        logic [31:0] prdata;
    } rx_state_t;
endpackage : msg_rx_pkg

// file: verilog/hdlc_bit_deframer.sv
// bit level deframer: flags, aborts, zero removal, bytes, check sequence
// assumes bits arrive lsb first with a one-cycle valid on pclk
`timescale 1ns/100ps
`include "msg_rx_defs.svh"
module hdlc_bit_deframer import msg_rx_pkg::*; (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // serial datalink bits
    input wire logic bit_in,
    input wire logic bit_valid,
    // framing events
    output dfr_evt_t evt
);
    dfr_state_t st;
    dfr_state_t next_st;

    // =========================================================
    // check sequence, one byte lsb first
    function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                             input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = (r[0] ^ d[i]) ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
        end
        crc_byte = r;
    endfunction : crc_byte

    // =========================================================
    // next state; flag has priority so its own bits never make a byte
    always_comb begin
        next_st = st;
        next_st.evt.flag = 1'b0;
        next_st.evt.byte_ok = 1'b0;
        if (bit_valid) begin
            next_st.shift = {bit_in, st.shift[7:1]};
            if (!bit_in) begin
                next_st.ones = 3'h0;
            end else if (st.ones != `ONES_ABORT) begin
                next_st.ones = st.ones + 3'h1;
            end
            next_st.evt.abort = (next_st.ones == `ONES_ABORT);
            if (next_st.shift == `FLAG_BYTE) begin
                next_st.evt.flag = 1'b1;
                next_st.evt.flag_on = 1'b1;
                next_st.evt.crc_good = (st.crc == `CRC_GOOD);
                next_st.nbits = 3'h0;
                next_st.crc = `CRC_INIT;
            end else if (next_st.ones == `ONES_ABORT) begin
                next_st.nbits = 3'h0;
                next_st.evt.flag_on = 1'b0;
            end else if (!(!bit_in && st.ones == `ONES_STUFF)) begin
                // a zero after five ones is stuffing and is dropped
                next_st.acc = {bit_in, st.acc[7:1]};
                next_st.nbits = st.nbits + 3'h1;
                if (st.nbits == 3'h7) begin
                    next_st.evt.byte_ok = 1'b1;
                    next_st.evt.data = next_st.acc;
                    next_st.evt.flag_on = 1'b0;
                    next_st.crc = crc_byte(st.crc, next_st.acc);
                end
            end
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign evt = st.evt;
endmodule : hdlc_bit_deframer

// file: verilog/payload_store.sv
// receive message buffer held in flip-flops, one write and one read port
// assumes writes come from the message logic on the same clock
`timescale 1ns/100ps
`include "msg_rx_defs.svh"
module payload_store import msg_rx_pkg::*; (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // write port
    input buf_wr_t wr,
    // read port
    input wire logic [6:0] rd_idx,
    output logic [7:0] rd_data
);
    buf_state_t st;
    buf_state_t next_st;

    // =========================================================
    // storage; out of range writes are dropped
    always_comb begin
        next_st = st;
        if (wr.en && wr.idx < `BUF_DEPTH) begin
            next_st.mem[wr.idx] = wr.data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // reads past the end return zero
    assign rd_data = (rd_idx < `BUF_DEPTH) ? st.mem[rd_idx] : 8'h00;
endmodule : payload_store

// file: dv/msg_tx_model.sv
// remote message transmitter model driving the serial datalink bits
// assumes the receiver takes one bit per pclk edge while valid is high
`timescale 1ns/100ps
`include "msg_rx_defs.svh"
module msg_tx_model (
    // clock
    input wire logic pclk,
    // serial datalink bits
    output logic bit_out,
    output logic bit_valid
);
    // ============================================================
    // bit helpers
    logic [15:0] crc;
    int ones;
    // quiet line at time zero
    initial begin
        bit_out = 1'b0;
        bit_valid = 1'b0;
    end
    // one bit per cycle, launched just after the edge
    task automatic put_bit(input logic b);
        @(posedge pclk);
        bit_out <= b;
        bit_valid <= 1'b1;
    endtask : put_bit
    // line toggles while idle so a stale bit never looks valid
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge pclk);
            bit_valid <= 1'b0;
            bit_out <= ~bit_out;
        end
    endtask : idle
    // lsb first, zero inserted after five ones unless raw
    task automatic send_byte(input logic [7:0] d, input bit raw);
        for (int i = 0; i < 8; i++) begin
            put_bit(d[i]);
            ones = (d[i] && !raw) ? ones + 1 : 0;
            if (ones == 5) begin
                put_bit(1'b0);
                ones = 0;
            end
        end
    endtask : send_byte
    // reflected check sequence, one byte
    task automatic crc_byte(input logic [7:0] d);
        for (int i = 0; i < 8; i++) begin
            crc = (crc[0] ^ d[i]) ? ((crc >> 1) ^ `CRC_POLY) : (crc >> 1);
        end
    endtask : crc_byte
    // ============================================================
    // frame level
    task automatic send_frame(input logic cr, input logic [1:0] kind, input int len,
            input bit bad, input logic [7:0] seed);
        logic [7:0] hdr [4];
        logic [7:0] d;
        hdr = '{{6'h0E, cr, 1'b0}, 8'h01, 8'h03, {6'h00, kind}};
        crc = `CRC_INIT;
        ones = 0;
        send_byte(`FLAG_BYTE, 1'b1);
        for (int i = 0; i < 4 + len; i++) begin
            d = (i < 4) ? hdr[i] : 8'(seed + 8'(5 * (i - 4)));
            crc_byte(d);
            send_byte(d, 1'b0);
        end
        // a bad frame flips one check bit
        crc = ~crc ^ {15'h0000, bad};
        send_byte(crc[7:0], 1'b0);
        send_byte(crc[15:8], 1'b0);
        send_byte(`FLAG_BYTE, 1'b1);
        idle(2);
    endtask : send_frame
    // run of ones with no stuffing, then quiet
    task automatic send_ones(input int n);
        repeat (n) put_bit(1'b1);
        idle(1);
    endtask : send_ones
    task automatic send_flag();
        send_byte(`FLAG_BYTE, 1'b1);
        idle(1);
    endtask : send_flag
endmodule : msg_tx_model

// file: dv/tb_top.sv
// self-checking bench for the datalink message receiver
// assumes design, package and transmitter model are compiled first
`timescale 1ns/100ps
`include "msg_rx_defs.svh"
module tb_top;
    // ============================================================
    // signals
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic dl_bit, dl_valid;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    int fails, n_tests;
    localparam logic [11:0] a_ctrl = 12'(`IDX_CTRL * 4);
    localparam logic [11:0] a_stat = 12'(`IDX_STAT * 4);
    localparam logic [11:0] a_evs = 12'(`IDX_EVT_STAT * 4);
    localparam logic [11:0] a_evc = 12'(`IDX_EVT_CLR * 4);
    localparam logic [11:0] a_een = 12'(`IDX_EVT_EN * 4);
    localparam logic [11:0] a_buf = 12'(`IDX_BUF * 4);
    // ============================================================
    // instances
    ds3_datalink_message_receiver i_ds3_datalink_message_receiver (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .datalink_overhead_bits(dl_bit),
        .datalink_bit_valid(dl_valid), .irq(irq));
    msg_tx_model i_msg_tx_model (.pclk(pclk), .bit_out(dl_bit), .bit_valid(dl_valid));
    // 20 mhz clock
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // ============================================================
    // tasks
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // one apb transfer, held until pready is seen at an edge
    task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
            output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // no bound here: only the watchdog ends a wait
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // zero wait states: pready in the first access cycle
        chk("pready wait", 32'(n), 32'h0000_0001);
    endtask : apb_xfer
    task automatic apb_wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb_xfer(1'b1, a, d, rd, err);
    endtask : apb_wr
    task automatic check_rd(input logic [11:0] a, input logic [31:0] mask,
            input logic [31:0] exp);
        logic [31:0] rd;
        logic err;
        apb_xfer(1'b0, a, 32'h0000_0000, rd, err);
        chk($sformatf("reg %h", a), rd & mask, exp);
    endtask : check_rd
    // software polls end of message instead of waiting on irq
    task automatic wait_done();
        logic [31:0] rd;
        logic err;
        int n;
        n = 0;
        do begin
            apb_xfer(1'b0, a_stat, 32'h0000_0000, rd, err);
            n++;
        end while (rd[1] !== 1'b1 && n < 50);
        chk("finished", {31'h0000_0000, rd[1]}, 32'h0000_0001);
    endtask : wait_done
    task automatic print_verdict();
        if (fails == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict
    // watchdog, several times the expected run
    initial begin
        repeat (60000) @(posedge pclk);
        fails++;
        print_verdict();
    end
    // ============================================================
    // main sequence
    initial begin : main_seq
        logic [31:0] rd;
        logic err;
        logic ien;
        logic cr;
        int len;
        logic [7:0] seed;
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        fails = 0;
        n_tests = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        check_rd(a_ctrl, 32'hFFFF_FFFF, 32'h0000_0000);
        check_rd(a_stat, 32'hFFFF_FFFF, 32'h0000_0000);
        // receiver still off: a whole frame is ignored
        i_msg_tx_model.send_frame(1'b1, 2'h0, 76, 1'b0, 8'h11);
        check_rd(a_stat, 32'h0000_0002, 32'h0000_0000);
        check_rd(a_ctrl, 32'hFFFF_FFFF, 32'h0000_0000);
        // every message kind, irq masked for kind 1
        for (int k = 0; k < 4; k++) begin
            ien = (k != 1);
            cr = k[0];
            len = (k == 3) ? 82 : 76;
            seed = 8'(k * 16 + 3);
            apb_wr(a_ctrl, {29'h0000_0000, 1'b1, ien, 1'b0});
            i_msg_tx_model.send_frame(cr, 2'(k), len, 1'b0, seed);
            wait_done();
            chk("irq", {31'h0000_0000, irq}, {31'h0000_0000, ien});
            check_rd(a_stat, 32'hFFFF_FFFF, 32'({1'b0, 2'(k), cr, 3'h3}));
            for (int i = 0; i < len; i++) begin
                check_rd(a_buf + 12'(4 * i), 32'hFFFF_FFFF, 32'(8'(seed + 8'(5 * i))));
            end
            check_rd(a_ctrl, 32'hFFFF_FFFF, {29'h0000_0000, 1'b1, ien, 1'b1});
            check_rd(a_ctrl, 32'hFFFF_FFFF, {29'h0000_0000, 1'b1, ien, 1'b0});
            // read clear lands at the access edge, irq settles after it
            @(posedge pclk);
            chk("irq", {31'h0000_0000, irq}, 32'h0000_0000);
        end
        // bad check sequence; end of message drops once the header is in
        fork
            i_msg_tx_model.send_frame(1'b0, 2'h2, 76, 1'b1, 8'h55);
            begin
                repeat (120) @(posedge pclk);
                check_rd(a_stat, 32'h0000_0002, 32'h0000_0000);
            end
        join
        wait_done();
        check_rd(a_stat, 32'h0000_0006, 32'h0000_0006);
        check_rd(a_evs, 32'h0000_0005, 32'h0000_0005);
        apb_wr(a_evc, 32'h0000_0007);
        check_rd(a_evs, 32'hFFFF_FFFF, 32'h0000_0000);
        // six ones are no abort, the seventh is
        i_msg_tx_model.send_ones(6);
        check_rd(a_stat, 32'h0000_0040, 32'h0000_0000);
        i_msg_tx_model.send_ones(1);
        check_rd(a_stat, 32'h0000_0041, 32'h0000_0040);
        // abort event through the event group; done flag cleared first
        check_rd(a_ctrl, 32'h0000_0001, 32'h0000_0001);
        check_rd(a_evs, 32'hFFFF_FFFF, 32'h0000_0002);
        apb_wr(a_een, 32'h0000_0002);
        @(posedge pclk);
        chk("irq", {31'h0000_0000, irq}, 32'h0000_0001);
        apb_wr(a_evc, 32'h0000_0002);
        @(posedge pclk);
        chk("irq", {31'h0000_0000, irq}, 32'h0000_0000);
        i_msg_tx_model.send_flag();
        check_rd(a_stat, 32'h0000_0041, 32'h0000_0001);
        // unmapped address is refused
        apb_xfer(1'b0, 12'h7F0, 32'h0000_0000, rd, err);
        chk("slverr", {31'h0000_0000, err}, 32'h0000_0001);
        chk("prdata", rd, 32'h0000_0000);
        print_verdict();
    end
endmodule : tb_top
